// ===== rtl/rss_pkg.sv
// Package: register map, field layout, reset values and strobe constants
package rss_pkg;
  // ****************************************************************
  // Register map (byte addresses, one byte each)
  // ****************************************************************
  localparam logic [7:0] RSS_ADDR_RAIL_SIX = 8'h25;
  localparam logic [7:0] RSS_ADDR_RAIL_SEVEN = 8'h26;
  localparam logic [7:0] RSS_ADDR_CTRL = 8'h40;
  localparam logic [7:0] RSS_ADDR_STAT = 8'h44;
  localparam logic [7:0] RSS_RAIL_SIX_RESET = 8'h63;
  localparam logic [3:0] RSS_RAIL_SEVEN_LOW_RESET = 4'h3;
  localparam logic [3:0] RSS_THIRD_RESET = 4'h0;
  localparam int RSS_HI_LSB = 4;
  localparam int RSS_LO_LSB = 0;
  // ****************************************************************
  // Strobe codes and timing
  // ****************************************************************
  localparam logic [3:0] RSS_STROBE_FIRST = 4'h1;
  localparam logic [3:0] RSS_STROBE_MAIN = 4'h3;
  localparam logic [3:0] RSS_STROBE_LAST = 4'hA;
  localparam int RSS_CLK_HZ = 20000000;
  localparam int RSS_STEP_US = 1;
  localparam int RSS_STEP_CYC = (RSS_CLK_HZ / 1000000) * RSS_STEP_US;
  localparam int RSS_CTRL_START = 0;
  localparam int RSS_CTRL_SEAL = 1;

  typedef enum logic [1:0] {
    RSS_IDLE,
    RSS_RUN,
    RSS_DONE
  } rss_state_t;

  typedef struct packed {
    logic load_switch;
    logic linear_regulator;
    logic third_output;
  } rss_rails_t;

  typedef struct packed {
    logic [3:0] load_switch_strobe_field;
    logic [3:0] linear_regulator_strobe_field;
    logic [3:0] third_output_strobe_field;
  } rss_fields_t;

  // True when a code assigns the rail to strobe step 3..10
  function automatic logic rss_code_active(input logic [3:0] code);
    return (code >= RSS_STROBE_MAIN) && (code <= RSS_STROBE_LAST);
  endfunction
endpackage

// ===== rtl/rss_step_timer.sv
// Step timer: one pulse every RSS_STEP_CYC cycles while running
`timescale 1ns/1ps
module rss_step_timer
  import rss_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic run,
  output logic tick
);
  logic [15:0] count;

  always_ff @(posedge sys_clk) begin
    if (rst || !run) begin
      count <= 16'h0000;
      tick <= 1'b0;
    end else if (count == 16'(RSS_STEP_CYC - 1)) begin
      count <= 16'h0000;
      tick <= 1'b1;
    end else begin
      count <= count + 16'h0001;
      tick <= 1'b0;
    end
  end
endmodule

// ===== rtl/rail_strobe_assignment.sv
// Strobe assignment registers and power-up step sequencer
//
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/1ps
// How it works
// - Register 0x25 resets to 0x63: load-switch field high, regulator low.
// - Register 0x26 bits 7-4 hold the third-output field, reset 0h.
// - A field code 3..10 enables its rail at the strobe step of that number.
// - Codes 0..2 and 11..15 never enable the rail; a start clears it like the others.
// - Regulator field resets to step three, load-switch field to step six.
// - Strobe steps one and two run only while the freshness seal is zero.
module rail_strobe_assignment
  import rss_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output rss_rails_t rail_enable,
  output logic [3:0] strobe_step,
  output logic strobe_pulse,
  output logic backup_strobe
);
  // ****************************************************************
  // Registers
  // ****************************************************************
  rss_fields_t fields;
  logic [3:0] seven_low;
  logic freshness_seal_flag;
  logic start_req;
  rss_state_t state;
  logic tick;
  logic wr_en;

  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fields.load_switch_strobe_field <= RSS_RAIL_SIX_RESET[7:4];
      fields.linear_regulator_strobe_field <= RSS_RAIL_SIX_RESET[3:0];
      fields.third_output_strobe_field <= RSS_THIRD_RESET;
      seven_low <= RSS_RAIL_SEVEN_LOW_RESET;
      freshness_seal_flag <= 1'b0;
    end else if (wr_en) begin
      if (wb_adr_i == RSS_ADDR_RAIL_SIX) begin
        fields.load_switch_strobe_field <= wb_dat_i[RSS_HI_LSB +: 4];
        fields.linear_regulator_strobe_field <= wb_dat_i[RSS_LO_LSB +: 4];
      end else if (wb_adr_i == RSS_ADDR_RAIL_SEVEN) begin
        fields.third_output_strobe_field <= wb_dat_i[RSS_HI_LSB +: 4];
        seven_low <= wb_dat_i[RSS_LO_LSB +: 4];
      end else if (wb_adr_i == RSS_ADDR_CTRL) begin
        freshness_seal_flag <= wb_dat_i[RSS_CTRL_SEAL];
      end
    end
  end

  // Start is a self-clearing pulse written to the control register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      start_req <= 1'b0;
    end else begin
      start_req <= wr_en && (wb_adr_i == RSS_ADDR_CTRL) &&
                   wb_dat_i[RSS_CTRL_START];
    end
  end

  // ****************************************************************
  // Wishbone slave: one wait state, unmapped reads return zero
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      wb_dat_o <= 32'h00000000;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i) begin
        unique case (wb_adr_i)
          RSS_ADDR_RAIL_SIX: wb_dat_o[7:0] <= {
            fields.load_switch_strobe_field,
            fields.linear_regulator_strobe_field};
          RSS_ADDR_RAIL_SEVEN: wb_dat_o[7:0] <= {
            fields.third_output_strobe_field, seven_low};
          RSS_ADDR_CTRL: wb_dat_o[7:0] <= {6'h00, freshness_seal_flag, 1'b0};
          RSS_ADDR_STAT: wb_dat_o[7:0] <= {
            2'(state), strobe_step, rail_enable[2:1]};
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  rss_step_timer u_timer (
    .sys_clk(sys_clk),
    .rst(rst),
    .run(state == RSS_RUN),
    .tick(tick)
  );

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= RSS_IDLE;
      strobe_step <= 4'h0;
    end else begin
      unique case (state)
        RSS_IDLE: begin
          if (start_req) begin
            state <= RSS_RUN;
            strobe_step <= freshness_seal_flag ? RSS_STROBE_MAIN
                                               : RSS_STROBE_FIRST;
          end
        end
        RSS_RUN: begin
          if (tick) begin
            if (strobe_step == RSS_STROBE_LAST) begin
              state <= RSS_DONE;
            end else begin
              strobe_step <= strobe_step + 4'h1;
            end
          end
        end
        RSS_DONE: begin
          if (start_req) begin
            state <= RSS_RUN;
            strobe_step <= freshness_seal_flag ? RSS_STROBE_MAIN
                                               : RSS_STROBE_FIRST;
          end
        end
        default: state <= RSS_IDLE;
      endcase
    end
  end

  // Pulse and enables at the tick that closes each step
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      strobe_pulse <= 1'b0;
      backup_strobe <= 1'b0;
      rail_enable <= '0;
    end else begin
      strobe_pulse <= (state == RSS_RUN) && tick;
      backup_strobe <= (state == RSS_RUN) && tick && !freshness_seal_flag &&
                       (strobe_step < RSS_STROBE_MAIN);
      if (start_req) begin
        rail_enable <= '0;
      end else if ((state == RSS_RUN) && tick) begin
        if (rss_code_active(fields.load_switch_strobe_field) &&
            fields.load_switch_strobe_field == strobe_step) begin
          rail_enable.load_switch <= 1'b1;
        end
        if (rss_code_active(fields.linear_regulator_strobe_field) &&
            fields.linear_regulator_strobe_field == strobe_step) begin
          rail_enable.linear_regulator <= 1'b1;
        end
        if (rss_code_active(fields.third_output_strobe_field) &&
            fields.third_output_strobe_field == strobe_step) begin
          rail_enable.third_output <= 1'b1;
        end
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_reset_values: assert property (@(posedge sys_clk)
    rst |=> fields.load_switch_strobe_field == RSS_RAIL_SIX_RESET[7:4] &&
      fields.linear_regulator_strobe_field == RSS_RAIL_SIX_RESET[3:0])
    else $error("rail six reset value wrong");
  a_third_reset: assert property (@(posedge sys_clk)
    rst |=> fields.third_output_strobe_field == RSS_THIRD_RESET)
    else $error("third field reset wrong");
  a_rail_assigned: assert property (@(posedge sys_clk) disable iff (rst)
    (state == RSS_RUN && tick && !start_req &&
     fields.linear_regulator_strobe_field == strobe_step &&
     strobe_step >= 4'h3) |=> rail_enable.linear_regulator)
    else $error("rail not enabled at its step");
  a_uncontrolled_rail: assert property (@(posedge sys_clk) disable iff (rst)
    (!rss_code_active(fields.third_output_strobe_field) &&
     !rail_enable.third_output && $stable(fields)) |=>
     !rail_enable.third_output)
    else $error("uncontrolled rail enabled");
  a_seal_skips: assert property (@(posedge sys_clk) disable iff (rst)
    backup_strobe |-> !$past(freshness_seal_flag))
    else $error("backup strobe with seal set");
  sequence s_step_tick;
    state == RSS_RUN && tick && strobe_step != RSS_STROBE_LAST;
  endsequence
  a_step_order: assert property (@(posedge sys_clk) disable iff (rst)
    s_step_tick |=> strobe_step == $past(strobe_step) + 4'h1)
    else $error("strobe step out of order");
  a_bus_ack: assert property (@(posedge sys_clk) disable iff (rst)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  a_start_seal: assert property (@(posedge sys_clk) disable iff (rst)
    (start_req && state != RSS_RUN && freshness_seal_flag) |=>
    strobe_step == 4'h3)
    else $error("sealed start not at step three");
endmodule

// ===== tb/rail_strobe_assignment_tb.sv
// Testbench for the strobe assignment registers and sequencer
`timescale 1ns/1ps
module rail_strobe_assignment_tb;
  import rss_pkg::*;
  typedef struct {
    logic [7:0] a;
    logic w;
    logic [3:0] s;
    logic [7:0] d;
    logic [7:0] e;
  } rss_row_t;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic wb_we_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_o;
  logic [31:0] rd;
  logic [3:0] strobe_step;
  logic wb_ack_o;
  logic strobe_pulse;
  logic backup_strobe;
  rss_rails_t rail_enable;
  int mismatches = 0;
  int n_checks = 0;
  // Reads, write-backs, a masked write, an unmapped place, control, status
  rss_row_t rows[13] = '{
    '{8'h25, 1'b0, 4'h1, 8'h00, 8'h63}, '{8'h26, 1'b0, 4'h1, 8'h00, 8'h03},
    '{8'h25, 1'b1, 4'h1, 8'hA3, 8'h00}, '{8'h25, 1'b1, 4'h0, 8'h55, 8'h00},
    '{8'h25, 1'b0, 4'h1, 8'h00, 8'hA3}, '{8'h26, 1'b1, 4'h1, 8'hF7, 8'h00},
    '{8'h26, 1'b0, 4'h1, 8'h00, 8'hF7}, '{8'h30, 1'b1, 4'h1, 8'hFF, 8'h00},
    '{8'h30, 1'b0, 4'h1, 8'h00, 8'h00}, '{8'h40, 1'b1, 4'h1, 8'h02, 8'h00},
    '{8'h40, 1'b0, 4'h1, 8'h00, 8'h02}, '{8'h40, 1'b1, 4'h1, 8'h00, 8'h00},
    '{8'h44, 1'b0, 4'h1, 8'h00, 8'h00}};

  rail_strobe_assignment rail_strobe_assignment_i (
    .sys_clk(sys_clk), .rst(rst), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .rail_enable(rail_enable),
    .strobe_step(strobe_step), .strobe_pulse(strobe_pulse),
    .backup_strobe(backup_strobe));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", n, e, g);
      mismatches++;
    end
  endtask

  task automatic wb(input logic [7:0] a, input logic w, input logic [3:0] s,
                    input logic [31:0] d);
    int t = 0;
    wb_adr_i <= a;
    wb_we_i <= w;
    wb_sel_i <= s;
    wb_dat_i <= d;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    // Ack is sampled at the edge; only the watchdog ends a stuck wait
    do begin
      @(posedge sys_clk);
      t++;
    end while (wb_ack_o !== 1'b1);
    chk("ack_wait", 32'h2, t);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge sys_clk);
  endtask

  function automatic logic on_by(input logic [3:0] c, input int s);
    return c >= 4'h3 && c <= 4'hA && c <= s;
  endfunction

  task automatic run_seq(input logic [3:0] ls, input logic [3:0] lr,
                         input logic [3:0] th, input logic seal);
    int np = 0;
    int nb = 0;
    int st = seal ? 3 : 1;
    int nx = 0;
    rss_rails_t ex;
    wb(RSS_ADDR_RAIL_SIX, 1'b1, 4'h1, {24'h0, ls, lr});
    wb(RSS_ADDR_RAIL_SEVEN, 1'b1, 4'h1, {24'h0, th, 4'h3});
    wb(RSS_ADDR_CTRL, 1'b1, 4'h1, {30'h0, seal, 1'b1});
    for (int i = 0; i < 400 && np < 11 - st; i++) begin
      @(negedge sys_clk);
      if (strobe_pulse === 1'b1) begin
        ex = '{on_by(ls, st + np), on_by(lr, st + np), on_by(th, st + np)};
        chk("rails", {29'h0, ex}, {29'h0, rail_enable});
        nx = (st + np == 10) ? 10 : st + np + 1;
        chk("step", nx, {28'h0, strobe_step});
        np++;
      end
      if (backup_strobe === 1'b1) begin
        nb++;
      end
    end
    chk("pulses", 11 - st, np);
    chk("backup", seal ? 0 : 2, nb);
    @(posedge sys_clk);
  endtask

  task automatic tally_and_finish;
    if (mismatches == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ****************************************************************
  // Stimulus
  // ****************************************************************
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    $display("unexpected watchdog expected done seen hang");
    mismatches++;
    tally_and_finish();
  end

  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    foreach (rows[i]) begin
      wb(rows[i].a, rows[i].w, rows[i].s, {24'h0, rows[i].d});
      if (!rows[i].w) begin
        chk("read", {24'h0, rows[i].e}, rd);
      end
    end
    for (int c = 0; c < 16; c++) begin
      run_seq(c[3:0], 4'hF - c[3:0], c[3:0] ^ 4'h5, c[0]);
    end
    wb(RSS_ADDR_RAIL_SIX, 1'b1, 4'h1, 32'h33);
    wb(RSS_ADDR_CTRL, 1'b1, 4'h1, 32'h3);
    repeat (30) @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    chk("rails_rst", 32'h0, {29'h0, rail_enable});
    chk("step_rst", 32'h0, {28'h0, strobe_step});
    @(posedge sys_clk);
    wb(RSS_ADDR_RAIL_SIX, 1'b0, 4'h1, 32'h0);
    chk("six_rst", 32'h63, rd);
    wb(RSS_ADDR_RAIL_SEVEN, 1'b0, 4'h1, 32'h0);
    chk("seven_rst", 32'h03, rd);
    tally_and_finish();
  end
endmodule
